// ==== scc_device.sv ====
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
//Contract
// - control bit0 picks pins or activity latches
// - control bit1 picks OR or AND
// - control bit2 picks reset input or strobe
// - power-up flag forces search match until cleared
// - control bit7 reports external supply
// - selected channel matches when equal to polarity
// - combine bit chooses AND or OR response
// - standard speed unless overdrive flag set
// - register read takes address, returns through 8Fh
// - inverted CRC16 over command, address, data
// - after read CRC, answer ones until reset
// - pin sample at byte preceding pin address
// - sampling read streams, CRC every 32 bytes
// - samples at command, status, CRC last bits
// - first CRC includes command, later ones not
// - strobe low on first two bits of samples
// - write byte then its inverse, 1 is off
// - latch only on good inverse, MSB timed
// - confirmation byte AAh with strobe
// - sample at confirmation MSB, send status, loop
// - no strobe for register-read pin sampling
// - reset input low forces outputs off, latch ones
module scc_device
    import scc_pkg::*;
#(
    parameter logic [15:0] RST_DET_CYC = 16'(cycDn(T_RSTDET_NS))
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    scc_link_if.dev         link,
    input  wire logic [7:0] chanIn,
    output logic      [7:0] chanOut,
    output logic      [7:0] chanOe,
    input  wire logic       resetStrobeIn,
    output logic            resetStrobeOut,
    output logic            resetStrobeOe,
    input  wire logic       externalSupplyFlag,
    output logic            searchResponse
);
    typedef enum logic [3:0] {
        S_CMD, S_ADDR_LO, S_ADDR_HI, S_REG_DATA, S_REG_CRC, S_ONES, S_STREAM, S_STREAM_CRC,
        S_WR_DATA, S_WR_INV, S_CONFIRM, S_STATUS, S_CS_ADDR_LO, S_CS_ADDR_HI, S_CS_DATA
    } scc_dev_e;

    typedef struct packed {
        scc_dev_e    st;
        logic [15:0] cnt;
        logic        inSlot;
        logic [15:0] lowCnt;
        logic        linePrev;
        logic        drive;
        logic [3:0]  bitIdx;
        logic [15:0] sh;
        logic [15:0] crc;
        logic [15:0] addr;
        logic [4:0]  byteCnt;
        logic [7:0]  newOut;
        logic        pendApply;
        logic        strobe;
        logic [7:0]  pinSnap;
        logic [7:0]  outLatch;
        logic [7:0]  actLatch;
        logic [7:0]  pinPrev;
        logic [7:0]  mask;
        logic [7:0]  pol;
        logic        srcSel;
        logic        combSel;
        logic        pinFunc;
        logic        powerup;
        logic        resp;
    } scc_dev_s;

    scc_dev_s q, d;

    function automatic logic isTx(input scc_dev_e s);
        return s inside {S_REG_DATA, S_REG_CRC, S_ONES, S_STREAM, S_STREAM_CRC, S_CONFIRM,
                         S_STATUS};
    endfunction : isTx

    function automatic logic [7:0] regByte(input scc_dev_s r, input logic [15:0] a,
                                           input logic [7:0] snap, input logic vcc);
        logic [7:0] ctrl;
        ctrl = 8'h00;
        ctrl[BIT_SRC] = r.srcSel;
        ctrl[BIT_CT]  = r.combSel;
        ctrl[BIT_PIN] = r.pinFunc;
        ctrl[BIT_POR] = r.powerup;
        ctrl[BIT_VCC] = vcc;
        unique case (a)
            ADDR_PIN:  return snap;
            ADDR_OUT:  return r.outLatch;
            ADDR_ACT:  return r.actLatch;
            ADDR_MASK: return r.mask;
            ADDR_POL:  return r.pol;
            ADDR_CTRL: return ctrl;
            default:   return (a > ADDR_CTRL && a <= ADDR_LAST) ? PAD_BYTE : UNDEF_BYTE;
        endcase
    endfunction : regByte

    always_comb begin
        logic        line, fall, rise, samp, bitv, done, busRst, rstIn;
        logic [15:0] smpC, holdC;
        logic [7:0]  rxb, snap, src, match;
        line  = link.lineLvl;
        d     = q;
        smpC  = link.overdriveFlag ? SMP_OD : SMP_STD;
        holdC = link.overdriveFlag ? HOLD_OD : HOLD_STD;
        fall  = q.linePrev && !line;
        rise  = !q.linePrev && line;
        samp  = q.inSlot && q.cnt == smpC - 16'd1;
        bitv  = isTx(q.st) ? q.sh[0] : line;
        done  = samp && (q.bitIdx == ((q.st inside {S_REG_CRC, S_STREAM_CRC}) ? 4'd15 : 4'd7));
        rxb   = {bitv, q.sh[15:9]};
        snap  = q.pinSnap;
        rstIn = !q.pinFunc && !resetStrobeIn;
        busRst = !line && q.lowCnt == RST_DET_CYC - 16'd1;
        d.linePrev = line;
        d.pinPrev  = chanIn;
        d.lowCnt   = line ? 16'd0 : (q.lowCnt < RST_DET_CYC ? q.lowCnt + 16'd1 : q.lowCnt);

        if (fall) begin
            d.inSlot = 1'b1;
            d.cnt    = 16'd0;
            d.drive  = isTx(q.st) && !q.sh[0];
        end else begin
            d.cnt = q.cnt + 16'd1;
            if (q.cnt == holdC - 16'd1) begin
                d.drive = 1'b0;
            end
        end
        if (rise && q.pendApply) begin
            d.outLatch  = q.newOut;
            d.pendApply = 1'b0;
        end

        if (samp) begin
            d.inSlot = 1'b0;
            d.sh     = {bitv, q.sh[15:1]};
            d.bitIdx = q.bitIdx + 4'd1;
            if (q.st inside {S_CMD, S_ADDR_LO, S_ADDR_HI, S_REG_DATA, S_STREAM}) begin
                d.crc = crcBit(q.crc, bitv);
            end
        end
        if (done) begin
            d.bitIdx = 4'd0;
            unique case (q.st)
                S_CMD: begin
                    unique case (rxb)
                        CMD_READ_REGS: d.st = S_ADDR_LO;
                        CMD_SAMPLE: begin
                            snap      = chanIn;
                            d.sh      = {8'h00, snap};
                            d.byteCnt = 5'd0;
                            d.st      = S_STREAM;
                        end
                        CMD_WRITE_CH: d.st = S_WR_DATA;
                        CMD_WRITE_CS: d.st = S_CS_ADDR_LO;
                        default:      d.st = S_ONES;
                    endcase
                end
                S_ADDR_LO: begin
                    d.addr = {8'h00, rxb};
                    d.st   = S_ADDR_HI;
                end
                S_ADDR_HI, S_REG_DATA: begin
                    d.addr = (q.st == S_ADDR_HI) ? {rxb, q.addr[7:0]} : q.addr + 16'd1;
                    if ((q.st == S_ADDR_HI && d.addr == ADDR_PIN) ||
                        (q.st == S_REG_DATA && q.addr == ADDR_PRE_PIN)) begin
                        snap = chanIn;
                    end
                    if (d.addr <= ADDR_LAST) begin
                        d.sh = {8'h00, regByte(q, d.addr, snap, externalSupplyFlag)};
                        d.st = S_REG_DATA;
                    end else begin
                        d.sh = ~d.crc;
                        d.st = S_REG_CRC;
                    end
                end
                S_REG_CRC: d.st = S_ONES;
                S_STREAM: begin
                    d.byteCnt = q.byteCnt + 5'd1;
                    if (q.byteCnt == STREAM_LAST) begin
                        d.sh = ~d.crc;
                        d.st = S_STREAM_CRC;
                    end else begin
                        snap = chanIn;
                        d.sh = {8'h00, snap};
                    end
                end
                S_STREAM_CRC: begin
                    snap      = chanIn;
                    d.sh      = {8'h00, snap};
                    d.crc     = 16'h0000;
                    d.byteCnt = 5'd0;
                    d.st      = S_STREAM;
                end
                S_WR_DATA: begin
                    d.newOut = rxb;
                    d.st     = S_WR_INV;
                end
                S_WR_INV: begin
                    if (rxb == ~q.newOut && !rstIn) begin
                        // A 1 bit ends early, so the change can start at the sample point
                        if (bitv) begin
                            d.outLatch = q.newOut;
                        end else begin
                            d.pendApply = 1'b1;
                        end
                        d.sh = {8'h00, CONFIRM_BYTE};
                        d.st = S_CONFIRM;
                    end else begin
                        d.st = S_ONES;
                    end
                end
                S_CONFIRM: begin
                    snap = chanIn;
                    d.sh = {8'h00, snap};
                    d.st = S_STATUS;
                end
                S_STATUS: d.st = S_WR_DATA;
                S_CS_ADDR_LO: begin
                    d.addr = {8'h00, rxb};
                    d.st   = S_CS_ADDR_HI;
                end
                S_CS_ADDR_HI: begin
                    d.addr = {rxb, q.addr[7:0]};
                    d.st   = S_CS_DATA;
                end
                S_CS_DATA: begin
                    if (q.addr == ADDR_MASK) d.mask = rxb;
                    if (q.addr == ADDR_POL) d.pol = rxb;
                    if (q.addr == ADDR_CTRL) begin
                        d.srcSel  = rxb[BIT_SRC];
                        d.combSel = rxb[BIT_CT];
                        d.pinFunc = rxb[BIT_PIN];
                        d.powerup = q.powerup & rxb[BIT_POR];
                    end
                    if (q.addr <= ADDR_CTRL) d.addr = q.addr + 16'd1;
                end
                S_ONES: d.st = S_ONES;
            endcase
        end
        if (q.st == S_ONES) begin
            d.sh = 16'hFFFF;
        end
        d.pinSnap = snap;

        // Strobe spans the first two bit slots of sample and confirmation bytes only
        d.strobe = q.pinFunc && (d.st inside {S_STREAM, S_CONFIRM}) &&
                   (d.bitIdx == 4'd1 || (d.bitIdx == 4'd0 && d.inSlot));

        // Activity: a new edge in the clearing cycle still sets the latch
        d.actLatch = (rstIn ? 8'h00 : q.actLatch) | (chanIn ^ q.pinPrev);
        if (rstIn) begin
            d.outLatch  = OUT_RESET;
            d.pendApply = 1'b0;
        end

        src     = q.srcSel ? q.actLatch : chanIn;
        match   = ~(src ^ q.pol);
        d.resp  = q.powerup || (q.combSel ? &(match | ~q.mask) : |(match & q.mask));

        if (busRst) begin
            d.st        = S_CMD;
            d.bitIdx    = 4'd0;
            d.crc       = 16'h0000;
            d.inSlot    = 1'b0;
            d.drive     = 1'b0;
            d.pendApply = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q          <= '0;
            q.st       <= S_CMD;
            q.linePrev <= 1'b1;
            q.outLatch <= OUT_RESET;
            q.powerup  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign link.devLineOe = q.drive;
    assign chanOut        = 8'h00;
    assign chanOe         = ~q.outLatch;
    assign resetStrobeOut = 1'b0;
    assign resetStrobeOe  = q.strobe;
    assign searchResponse = q.resp;
endmodule : scc_device
`default_nettype wire

// ==== scc_pkg.sv ====
package scc_pkg;
    localparam int CLK_NS = 50;

    function automatic int cycUp(input int ns);
        return (ns + CLK_NS - 1) / CLK_NS;
    endfunction : cycUp

    function automatic int cycDn(input int ns);
        return (ns / CLK_NS < 1) ? 1 : ns / CLK_NS;
    endfunction : cycDn

    // Slot timing, standard and overdrive, in ns
    localparam int T_SMP_STD_NS   = 20000;
    localparam int T_SMP_OD_NS    = 2000;
    localparam int T_HOLD_STD_NS  = 30000;
    localparam int T_HOLD_OD_NS   = 3000;
    localparam int T_WR0_STD_NS   = 60000;
    localparam int T_WR0_OD_NS    = 7000;
    localparam int T_LOW_STD_NS   = 2000;
    localparam int T_LOW_OD_NS    = 1000;
    localparam int T_HRD_STD_NS   = 10000;
    localparam int T_HRD_OD_NS    = 1500;
    localparam int T_SLOT_STD_NS  = 70000;
    localparam int T_SLOT_OD_NS   = 10000;
    localparam int T_RST_NS       = 480000;
    localparam int T_RSTDET_NS    = 400000;

    localparam logic [15:0] SMP_STD  = 16'(cycUp(T_SMP_STD_NS));
    localparam logic [15:0] SMP_OD   = 16'(cycUp(T_SMP_OD_NS));
    localparam logic [15:0] HOLD_STD = 16'(cycDn(T_HOLD_STD_NS));
    localparam logic [15:0] HOLD_OD  = 16'(cycDn(T_HOLD_OD_NS));
    localparam logic [15:0] WR0_STD  = 16'(cycUp(T_WR0_STD_NS));
    localparam logic [15:0] WR0_OD   = 16'(cycUp(T_WR0_OD_NS));
    localparam logic [15:0] LOW_STD  = 16'(cycUp(T_LOW_STD_NS));
    localparam logic [15:0] LOW_OD   = 16'(cycUp(T_LOW_OD_NS));
    localparam logic [15:0] HRD_STD  = 16'(cycDn(T_HRD_STD_NS));
    localparam logic [15:0] HRD_OD   = 16'(cycDn(T_HRD_OD_NS));
    localparam logic [15:0] SLOT_STD = 16'(cycUp(T_SLOT_STD_NS));
    localparam logic [15:0] SLOT_OD  = 16'(cycUp(T_SLOT_OD_NS));

    // Command codes and register page
    localparam logic [7:0]  CMD_READ_REGS = 8'hF0;
    localparam logic [7:0]  CMD_SAMPLE    = 8'hF5;
    localparam logic [7:0]  CMD_WRITE_CH  = 8'h5A;
    localparam logic [7:0]  CMD_WRITE_CS  = 8'hCC;
    localparam logic [7:0]  CONFIRM_BYTE  = 8'hAA;
    localparam logic [15:0] ADDR_PRE_PIN  = 16'h0087;
    localparam logic [15:0] ADDR_PIN      = 16'h0088;
    localparam logic [15:0] ADDR_OUT      = 16'h0089;
    localparam logic [15:0] ADDR_ACT      = 16'h008A;
    localparam logic [15:0] ADDR_MASK     = 16'h008B;
    localparam logic [15:0] ADDR_POL      = 16'h008C;
    localparam logic [15:0] ADDR_CTRL     = 16'h008D;
    localparam logic [15:0] ADDR_LAST     = 16'h008F;
    localparam logic [7:0]  UNDEF_BYTE    = 8'h00;
    localparam logic [7:0]  PAD_BYTE      = 8'hFF;
    localparam logic [7:0]  OUT_RESET     = 8'hFF;
    localparam int BIT_SRC = 0;
    localparam int BIT_CT  = 1;
    localparam int BIT_PIN = 2;
    localparam int BIT_POR = 3;
    localparam int BIT_VCC = 7;
    localparam logic [4:0]  STREAM_LAST   = 5'd31;
    localparam logic [15:0] CRC_POLY      = 16'hA001;

    // Host controller register map (AXI4-Lite byte offsets)
    localparam logic [3:0] HREG_CMD    = 4'h0;
    localparam logic [3:0] HREG_STATUS = 4'h4;
    localparam logic [3:0] HREG_CFG    = 4'h8;
    localparam logic [1:0] OP_RESET    = 2'd1;
    localparam logic [1:0] OP_WRITE    = 2'd2;
    localparam logic [1:0] OP_READ     = 2'd3;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // One bit into the reflected CRC16 generator, LSB first
    function automatic logic [15:0] crcBit(input logic [15:0] c, input logic b);
        return (c[0] ^ b) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    endfunction : crcBit
endpackage : scc_pkg

// ==== scc_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface scc_link_if;
    logic hostLineOe;
    logic devLineOe;
    logic overdriveFlag;
    logic lineLvl;
    // Open-drain data line with pull-up: low while either end drives
    assign lineLvl = !(hostLineOe || devLineOe);
    modport dev (input lineLvl, input overdriveFlag, output devLineOe);
    modport host (input lineLvl, output hostLineOe, output overdriveFlag);
endinterface : scc_link_if
`default_nettype wire

// ==== scc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module scc_host
    import scc_pkg::*;
#(
    parameter logic [15:0] RST_CYC = 16'(cycDn(T_RST_NS))
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    scc_link_if.host         link,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [3:0]  awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic      [1:0]  bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [3:0]  araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic      [31:0] rdata,
    output logic      [1:0]  rresp
);
    typedef enum logic [1:0] {H_IDLE, H_RST_LOW, H_RST_REC, H_SLOT} scc_host_e;

    typedef struct packed {
        scc_host_e   st;
        logic [15:0] cnt;
        logic [2:0]  bitIdx;
        logic [1:0]  op;
        logic [7:0]  tx;
        logic [7:0]  rx;
        logic        od;
        logic        oe;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } scc_host_s;

    scc_host_s q, d;
    logic      wrTake;

    assign wrTake  = awvalid && wvalid && !q.bvalid;
    assign awready = wrTake;
    assign wready  = wrTake;
    assign arready = !q.rvalid;

    always_comb begin
        logic [15:0] lowC, hrdC, slotC;
        d     = q;
        lowC  = (q.op == OP_WRITE && !q.tx[0]) ? (q.od ? WR0_OD : WR0_STD)
                                               : (q.od ? LOW_OD : LOW_STD);
        hrdC  = q.od ? HRD_OD : HRD_STD;
        slotC = q.od ? SLOT_OD : SLOT_STD;
        d.cnt = q.cnt + 16'd1;

        if (bready) d.bvalid = 1'b0;
        if (rready) d.rvalid = 1'b0;
        if (wrTake) begin
            d.bvalid = 1'b1;
            d.bresp  = RESP_OKAY;
            unique case (awaddr)
                HREG_CMD: begin
                    // Commands while busy are dropped; software polls busy first
                    if (q.st == H_IDLE && wstrb[0] && wdata[1:0] != 2'd0) begin
                        d.op     = wdata[1:0];
                        d.tx     = wdata[15:8];
                        d.cnt    = 16'd0;
                        d.bitIdx = 3'd0;
                        d.oe     = 1'b1;
                        d.st     = (wdata[1:0] == OP_RESET) ? H_RST_LOW : H_SLOT;
                    end
                end
                HREG_CFG: if (wstrb[0]) d.od = wdata[0];
                HREG_STATUS: ;
                default: d.bresp = RESP_SLVERR;
            endcase
        end
        if (arvalid && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rresp  = RESP_OKAY;
            unique case (araddr)
                HREG_STATUS: d.rdata = {16'h0000, q.rx, 6'd0, q.od, q.st != H_IDLE};
                HREG_CFG:    d.rdata = {31'd0, q.od};
                HREG_CMD:    d.rdata = {16'h0000, q.tx, 6'd0, q.op};
                default: begin
                    d.rdata = 32'h0000_0000;
                    d.rresp = RESP_SLVERR;
                end
            endcase
        end

        unique case (q.st)
            H_IDLE: d.cnt = 16'd0;
            H_RST_LOW: if (q.cnt == RST_CYC - 16'd1) begin
                d.oe  = 1'b0;
                d.cnt = 16'd0;
                d.st  = H_RST_REC;
            end
            H_RST_REC: if (q.cnt == RST_CYC - 16'd1) d.st = H_IDLE;
            H_SLOT: begin
                if (q.cnt == lowC - 16'd1) d.oe = 1'b0;
                if (q.cnt == hrdC - 16'd1) d.rx = {link.lineLvl, q.rx[7:1]};
                if (q.cnt == slotC - 16'd1) begin
                    d.tx     = {1'b1, q.tx[7:1]};
                    d.bitIdx = q.bitIdx + 3'd1;
                    d.cnt    = 16'd0;
                    if (q.bitIdx == 3'd7) begin
                        d.st = H_IDLE;
                    end else begin
                        d.oe = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q    <= '0;
            q.st <= H_IDLE;
        end else begin
            q <= d;
        end
    end

    assign link.hostLineOe    = q.oe;
    assign link.overdriveFlag = q.od;
    assign bvalid             = q.bvalid;
    assign bresp              = q.bresp;
    assign rvalid             = q.rvalid;
    assign rdata              = q.rdata;
    assign rresp              = q.rresp;
endmodule : scc_host
`default_nettype wire

// ==== scc_link_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module scc_link_sva
    import scc_pkg::*;
#(
    parameter int RST_CYC = 40
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hostLineOe,
    input wire logic devLineOe,
    input wire logic overdriveFlag,
    input wire logic lineLvl
);
    // Bus reset also holds the line low, so it widens the upper bounds
    localparam int MAX_OD  = (int'(WR0_OD) > RST_CYC) ? int'(WR0_OD) : RST_CYC;
    localparam int MAX_STD = (int'(WR0_STD) > RST_CYC) ? int'(WR0_STD) : RST_CYC;
    logic [15:0] hostLow_q;
    logic [15:0] devLow_q;
    always_ff @(posedge ref_clk) begin
        hostLow_q <= (rst || !hostLineOe) ? 16'h0000 : hostLow_q + 16'h0001;
        devLow_q  <= (rst || !devLineOe) ? 16'h0000 : devLow_q + 16'h0001;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence sDevGrab;
        $rose(devLineOe);
    endsequence
    sequence sHostEnd;
        $fell(hostLineOe);
    endsequence
    // Device answers right at slot start so the host sample sees it
    a_dev_answer_early: assert property (sDevGrab |-> $past(hostLow_q) <= 16'd1)
        else $error("device answered late in the slot");
    a_dev_in_slot: assert property (sDevGrab |-> $past(hostLineOe))
        else $error("device drove outside a slot");
    a_dev_hold_std: assert property (devLow_q <= HOLD_STD)
        else $error("device held line too long");
    a_dev_hold_od: assert property (overdriveFlag |-> devLow_q <= HOLD_OD)
        else $error("device held line too long in overdrive");
    a_host_low_od: assert property (overdriveFlag |-> hostLow_q <= MAX_OD)
        else $error("host low too long in overdrive");
    a_host_low_std: assert property (hostLow_q <= MAX_STD)
        else $error("host low too long");
    a_host_low_min: assert property (sHostEnd |->
        hostLow_q >= (overdriveFlag ? LOW_OD : LOW_STD))
        else $error("host low pulse too short");
    a_od_idle: assert property ($changed(overdriveFlag) |-> $past(!hostLineOe))
        else $error("speed changed inside a slot");
    a_reset_quiet: assert property ($fell(rst) |-> !hostLineOe && !devLineOe)
        else $error("line driven after reset");
endmodule : scc_link_sva
`default_nettype wire

// ==== switch_control_commands_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module switch_control_commands_bench import scc_pkg::*;;
    logic ref_clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, stbOe, srchRsp, stbPrev;
    logic [3:0] awaddr, araddr;
    logic [1:0] bresp, rresp;
    logic [31:0] wdata, rdata;
    logic [7:0] pinExt, chanIn, chanOe;
    int n_errors, cmp_count, stbCnt;
    scc_link_if scc_link_if_inst();
    // Pins pulled up, pulled low by the outside or by an enabled transistor
    assign chanIn = pinExt & ~chanOe;
    // Reset detect must outlast the longest slot low (overdrive write 0, 140 cycles; standard write 0 is 1200)
    scc_device #(.RST_DET_CYC(16'd160)) scc_device_inst(.ref_clk(ref_clk), .rst(rst),
        .link(scc_link_if_inst.dev), .chanIn(chanIn), .chanOut(), .chanOe(chanOe),
        .resetStrobeIn(!stbOe), .resetStrobeOut(), .resetStrobeOe(stbOe),
        .externalSupplyFlag(1'b1), .searchResponse(srchRsp));
    scc_host #(.RST_CYC(16'd200)) scc_host_inst(.ref_clk(ref_clk), .rst(rst),
        .link(scc_link_if_inst.host), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp));
    scc_link_sva #(.RST_CYC(200)) scc_link_sva_inst(.ref_clk(ref_clk), .rst(rst),
        .hostLineOe(scc_link_if_inst.hostLineOe), .devLineOe(scc_link_if_inst.devLineOe),
        .overdriveFlag(scc_link_if_inst.overdriveFlag), .lineLvl(scc_link_if_inst.lineLvl));
    initial begin
        ref_clk = 0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (stbOe === 1'b1 && stbPrev !== 1'b1) stbCnt++;
        stbPrev = stbOe;
    end
    task print_verdict;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task axiWr(input logic [3:0] a, input logic [31:0] d);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= d;
        bready <= 1'b1;
        do @(posedge ref_clk); while (!(awready === 1'b1 && wready === 1'b1));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge ref_clk); while (bvalid !== 1'b1);
        chk(bresp, RESP_OKAY);
        bready <= 1'b0;
        @(posedge ref_clk);
    endtask : axiWr
    task axiRd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge ref_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge ref_clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge ref_clk);
    endtask : axiRd
    task op(input logic [1:0] o, input logic [7:0] b, output logic [7:0] rb);
        logic [31:0] d;
        logic [1:0] r;
        axiWr(HREG_CMD, {16'h0000, b, 6'h00, o});
        do axiRd(HREG_STATUS, d, r); while (d[0] !== 1'b0);
        rb = d[15:8];
    endtask : op
    // Bus reset, then the bytes in order; reads return what the device sent
    task run(input logic [7:0] tx[$], input int nRd, output logic [7:0] rx[$]);
        logic [7:0] b;
        rx = {};
        op(OP_RESET, 8'h00, b);
        foreach (tx[i]) op(OP_WRITE, tx[i], b);
        repeat (nRd) begin
            op(OP_READ, 8'hFF, b);
            rx.push_back(b);
        end
    endtask : run
    task tRegs;
        logic [31:0] d;
        logic [1:0] r;
        axiRd(HREG_CFG, d, r);
        chk(d, 32'h0);
        axiWr(HREG_CFG, 32'h1);
        axiRd(HREG_STATUS, d, r);
        chk(d[1], 1'b1);
        axiRd(4'hC, d, r);
        chk(r, RESP_SLVERR);
    endtask : tRegs
    task tSearch(input logic [7:0] ctl, input logic [2:0] exp);
        logic [7:0] rx[$];
        logic [7:0] pins[3];
        pins = '{8'h01, 8'h02, 8'h00};
        run('{CMD_WRITE_CS, 8'h8B, 8'h00, 8'h03, 8'h01, ctl}, 0, rx);
        for (int i = 0; i < 3; i++) begin
            pinExt <= pins[i];
            repeat (4) @(posedge ref_clk);
            chk(srchRsp, exp[i]);
        end
    endtask : tSearch
    task tWrite;
        logic [7:0] rx[$];
        pinExt <= 8'hF0;
        stbCnt = 0;
        run('{CMD_WRITE_CH, 8'h5C, 8'hA3}, 2, rx);
        chk(chanOe, 8'hA3);
        chk({rx[0], rx[1]}, {CONFIRM_BYTE, 8'h50});
        chk(stbCnt, 1);
        run('{CMD_WRITE_CH, 8'h00, 8'h00}, 1, rx);
        chk({chanOe, rx[0]}, {8'hA3, 8'hFF});
    endtask : tWrite
    task tRead;
        logic [7:0] rx[$];
        logic [7:0] e[7];
        logic [7:0] bs[6];
        logic [15:0] c;
        c = 16'h0000;
        e = '{8'h86, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF};
        bs = '{CMD_READ_REGS, 8'h8D, 8'h00, 8'h86, 8'hFF, 8'hFF};
        // Reference generator over command, address and page bytes, bit 0 first
        foreach (bs[i])
            for (int j = 0; j < 8; j++)
                c = (c[0] ^ bs[i][j]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        {e[4], e[3]} = ~c;
        stbCnt = 0;
        run('{CMD_SAMPLE}, 1, rx);
        chk({rx[0], 8'(stbCnt)}, {8'h50, 8'h01});
        run('{CMD_READ_REGS, 8'h8D, 8'h00}, 7, rx);
        foreach (e[k]) chk(rx[k], e[k]);
    endtask : tRead
    initial begin
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        pinExt = 8'hF0;
        {n_errors, cmp_count, stbCnt} = '0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk(srchRsp, 1'b1);
        tRegs;
        tSearch(8'h00, 3'b101);
        tSearch(8'h06, 3'b001);
        tWrite;
        tRead;
        print_verdict;
    end
    initial begin
        repeat (98000) @(posedge ref_clk);
        n_errors++;
        print_verdict;
    end
endmodule : switch_control_commands_bench
`default_nettype wire
